/* File: bench/meter_pulse_source.sv */
// Behavioural contact water meter that emits trigger pulses on command.
`timescale 1ns/1ps
`default_nettype none
module meter_pulse_source (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       go_in,
  input  wire logic [7:0] count_in,
  output logic            trig_out,
  output logic            busy_out
);
  logic [7:0] left_r;   // Pulses still to be sent.
  logic [2:0] phase_r;  // Position inside the eight-cycle pulse period.
  //////////////////////////////////////////////////////////////////////
  // Each pulse is high four cycles and low four, so the synchroniser
  // always sees a clean edge; a faster meter would merge pulses.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      left_r  <= 8'h00;
      phase_r <= 3'h0;
    end else if (go_in) begin
      left_r  <= count_in;
      phase_r <= 3'h0;
    end else if (left_r != 8'h00) begin
      phase_r <= phase_r + 3'h1;
      if (phase_r == 3'h7) begin
        left_r <= left_r - 8'h01;
      end
    end
  end
  // The contact line rests low between pulses.
  assign trig_out = (left_r != 8'h00) && !phase_r[2];
  assign busy_out = (left_r != 8'h00);
endmodule // meter_pulse_source
`default_nettype wire

/* File: bench/pulse_to_stroke_scaler_bench.sv */
// Self-checking bench for the pulse to stroke scaler.
`timescale 1ns/1ps
`default_nettype none
module pulse_to_stroke_scaler_bench;
  import stroke_scaler_pkg::*;
  logic        clk = 1'b0;         // 20 MHz system clock.
  logic        rst = 1'b1;         // Synchronous reset.
  logic        psel = 1'b0;        // APB select.
  logic        penable = 1'b0;     // APB access phase.
  logic        pwrite = 1'b0;      // APB direction.
  logic [7:0]  paddr = 8'h00;      // APB address.
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;             // APB read data.
  logic        pready;             // APB ready.
  logic        pslverr;            // APB error.
  logic        trig;               // Trigger from the meter.
  logic        stroke_done = 1'b0; // Pump stroke executed.
  logic [6:0]  stroke_len = 7'h28; // Stroke length, 40 divisions.
  logic        stroke_req;         // Stroke request.
  ind_t        ind;                // Indicators.
  logic        irq;                // Interrupt.
  logic        go = 1'b0;          // Meter start.
  logic [7:0]  cnt = 8'h00;        // Meter pulse count.
  logic        busy;               // Meter busy.
  logic        pump_en = 1'b1;     // Pump answers requests.
  logic [31:0] rd;                 // Last read data.
  logic        err;                // Last error flag.
  int          strokes = 0;        // Strokes done by the pump.
  int          base;               // Stroke count snapshot.
  int          num_errors = 0;     // Mismatches.
  int          checked = 0;        // Comparisons.
  logic [6:0]  lens [4] = '{7'h32, 7'h1E, 7'h33, 7'h1D};
  //////////////////////////////////////////////////////////////////////
  pulse_to_stroke_scaler #(.BLINK_N(4)) u_dut (
    .clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .trig_in(trig), .stroke_done_in(stroke_done),
    .stroke_len_in(stroke_len), .stroke_req_out(stroke_req),
    .ind_out(ind), .irq_out(irq));
  meter_pulse_source u_meter (.clk_in(clk), .reset_in(rst), .go_in(go),
    .count_in(cnt), .trig_out(trig), .busy_out(busy));
  initial begin
    forever #25 clk = ~clk;
  end
  // Pump model: one-cycle done pulse, never two in a row, when enabled.
  always @(posedge clk) begin
    stroke_done <= pump_en && stroke_req && !stroke_done;
    if (stroke_done) begin
      strokes <= strokes + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("Checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_bit(input string n, input logic e, input logic g);
    chk_val(n, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask
  // One APB transfer; the idle edge at the end keeps drivers apart.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge clk);
    if (n >= 50) begin
      num_errors++;
      end_of_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk_val(n, e, rd);
  endtask
  // Lets requests appear, then waits for an enabled pump to drain them.
  task settle;
    int i;
    repeat (6) @(posedge clk);
    for (i = 0; i < 400 && pump_en && stroke_req !== 1'b0; i++) begin
      @(posedge clk);
    end
    if (i >= 400) begin
      num_errors++;
      end_of_test;
    end
    repeat (2) @(posedge clk);
  endtask
  task pulses(input logic [7:0] n);
    int i;
    go <= 1'b1;
    cnt <= n;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 3000 && busy; i++) @(posedge clk);
    if (i >= 3000) begin
      num_errors++;
      end_of_test;
    end
    settle();
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk("factor reset", OFF_FACTOR, 32'h0000_0064);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk_bit("unmapped error", 1'b1, err);
    wr(OFF_CTRL, 32'h0000_0001);
    wr(OFF_FACTOR, 32'h0000_09C4);
    base = strokes;
    pulses(8'h01);
    chk_val("factor 25", 32'h0000_0019, strokes - base);
    wr(OFF_FACTOR, 32'h0000_004B);
    for (int i = 0; i < 4; i++) begin
      base = strokes;
      pulses(8'h01);
      chk_val("factor 0.75", {31'h0000_0000, i != 0}, strokes - base);
    end
    wr(OFF_FACTOR, 32'h0000_000A);
    base = strokes;
    pulses(8'h0A);
    chk_val("factor 0.1", 32'h0000_0001, strokes - base);
    wr(OFF_FACTOR, 32'h0000_0096);
    base = strokes;
    pulses(8'h02);
    chk_val("factor 1.5", 32'h0000_0003, strokes - base);
    wr(OFF_FACTOR, 32'h0000_0000);
    rdchk("factor zero", OFF_FACTOR, 32'h0000_0096);
    wr(OFF_FACTOR, 32'h0000_270F);
    rdchk("factor max", OFF_FACTOR, 32'h0000_270F);
    wr(OFF_FACTOR, 32'h0000_2710);
    rdchk("factor over", OFF_FACTOR, 32'h0000_270F);
    wr(OFF_FACTOR, 32'h0000_00C8);
    pump_en <= 1'b0;
    pulses(8'h02);
    rdchk("no memory backlog", OFF_STAT, 32'h0000_0002);
    apb(1'b0, OFF_IRQ, 32'h0000_0000);
    chk_bit("discard irq", 1'b1, rd[IRQ_DISCARD]);
    wr(OFF_CTRL, 32'h0000_0002);
    rdchk("mode change backlog", OFF_STAT, 32'h0000_0000);
    rdchk("mode change factor", OFF_FACTOR, 32'h0000_0064);
    wr(OFF_BATCH, 32'h0000_0000);
    rdchk("batch zero", OFF_BATCH, 32'h0000_0001);
    wr(OFF_BATCH, 32'h0000_0003);
    wr(OFF_CTRL, 32'h0000_0012);
    wr(OFF_CTRL, 32'h0000_0012);
    rdchk("batch cap", OFF_STAT, 32'h0000_0003);
    pump_en <= 1'b1;
    base = strokes;
    settle();
    chk_val("batch drain", 32'h0000_0003, strokes - base);
    base = strokes;
    pulses(8'h01);
    chk_val("batch trigger", 32'h0000_0003, strokes - base);
    wr(OFF_QTY, 32'h0000_000A);
    wr(OFF_VOL, 32'h0000_0003);
    wr(OFF_CTRL, 32'h0000_000A);
    base = strokes;
    wr(OFF_CTRL, 32'h0000_001A);
    settle();
    chk_val("quantity form", 32'h0000_0004, strokes - base);
    pump_en <= 1'b0;
    wr(OFF_CTRL, 32'h0000_0006);
    wr(OFF_BATCH, 32'h0000_FFFF);
    wr(OFF_CTRL, 32'h0000_0016);
    rdchk("memory full", OFF_STAT, 32'h0000_FFFF);
    chk_bit("memory lamp", 1'b1, ind.mem_ind);
    wr(OFF_CTRL, 32'h0000_0016);
    apb(1'b0, OFF_STAT, 32'h0000_0000);
    chk_bit("overflow fault", 1'b1, rd[STAT_FAULT]);
    chk_bit("fault stops pump", 1'b0, stroke_req);
    wr(OFF_MASK, 32'h0000_0001);
    chk_bit("irq raised", 1'b1, irq);
    wr(OFF_CTRL, 32'h0000_0046);
    wr(OFF_IRQ, 32'h0000_000F);
    chk_bit("irq cleared", 1'b0, irq);
    wr(OFF_CTRL, 32'h0000_0020);
    rdchk("manual backlog", OFF_STAT, 32'h0142_0000);
    for (int i = 0; i < 4; i++) begin
      stroke_len <= lens[i];
      repeat (2) @(posedge clk);
      chk_bit("drift lamp", i > 1, ind.warn_lamp);
    end
    base = 0;
    repeat (8) begin
      @(posedge clk);
      base += ind.disp_flash + ind.calib_flash;
    end
    chk_val("flash duty", 32'h0000_0008, base);
    end_of_test;
  end
endmodule // pulse_to_stroke_scaler_bench
`default_nettype wire

/* File: verilog/pulse_to_stroke_scaler.sv */
// Pulse to stroke scaler with APB registers, backlog and drift check.
//
// Behaviour
// - Contact mode: strokes equal factor times pulses.
// - Factor accepted from 0.01 to 99.99.
// - Integer factor N gives N strokes per pulse.
// - Reduction factor: one stroke per reciprocal pulses.
// - Fraction remainders accumulate into extra strokes.
// - Factor 0.75 gives 2,1,1 pulse pattern.
// - Leaving contact mode resets the factor.
// - Memory option stores up to 65535 strokes.
// - Backlog overflow enters the fault state.
// - Batch size integer from 1 to 65535.
// - Batch set as strokes or metering quantity.
// - Batch starts on command or trigger pulse.
// - Batch backlog capped by size or 65535.
// - Mode change clears the stroke backlog.
// - Calibration valid within 10 divisions.
// - Drift over 10 divisions lights warning indicators.
`timescale 1ns/1ps
`default_nettype none
module pulse_to_stroke_scaler
  import stroke_scaler_pkg::*;
#(
  parameter int BLINK_N = BLINK_CYCLES  // Flash half period in cycles.
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        trig_in,
  input  wire logic        stroke_done_in,
  input  wire logic [6:0]  stroke_len_in,
  output logic             stroke_req_out,
  output ind_t             ind_out,
  output logic             irq_out
);

  //////////////////////////////////////////////////////////////////////////
  // Bus decode.
  //////////////////////////////////////////////////////////////////////////
  // A write or read takes effect in the single access cycle.
  wire        wr_en   = psel_in & penable_in & pwrite_in;
  wire        rd_en   = psel_in & penable_in & ~pwrite_in;
  wire        sel_ctl = (paddr_in == OFF_CTRL);
  wire        sel_fac = (paddr_in == OFF_FACTOR);
  wire        sel_bat = (paddr_in == OFF_BATCH);
  wire        sel_qty = (paddr_in == OFF_QTY);
  wire        sel_vol = (paddr_in == OFF_VOL);
  wire        sel_sta = (paddr_in == OFF_STAT);
  wire        sel_irq = (paddr_in == OFF_IRQ);
  wire        sel_msk = (paddr_in == OFF_MASK);
  wire        mapped  = sel_ctl | sel_fac | sel_bat | sel_qty | sel_vol
                        | sel_sta | sel_irq | sel_msk;

  //////////////////////////////////////////////////////////////////////////
  // State.
  //////////////////////////////////////////////////////////////////////////
  ctrl_t               ctrl_r;        // Mode and option bits.
  logic [13:0]         factor_r;      // Contact factor in hundredths.
  logic [13:0]         frac_r;        // Carried fraction, hundredths.
  logic [15:0]         batch_r;       // Batch size in strokes.
  logic [15:0]         qty_r;         // Batch metering quantity.
  logic [15:0]         vol_r;         // Quantity per stroke.
  logic [15:0]         pend_r;        // Pending stroke backlog.
  logic                fault_r;       // Backlog overflow fault.
  logic                calv_r;        // Calibration taken.
  logic [6:0]          calpt_r;       // Stroke length at calibration.
  logic [IRQ_W-1:0]    irq_r;         // Sticky event bits.
  logic [IRQ_W-1:0]    mask_r;        // Interrupt enables.
  logic [2:0]          sync_r;        // Trigger synchroniser and edge.
  logic [31:0]         blink_cnt_r;   // Flash divider.
  logic                blink_r;       // Flash phase.
  logic [31:0]         prdata_r;      // Registered read data.
  logic                pslverr_r;     // Registered error answer.

  //////////////////////////////////////////////////////////////////////////
  // Trigger and commands.
  //////////////////////////////////////////////////////////////////////////
  // Only the second and third stages feed the edge detector.
  wire pulse = sync_r[1] & ~sync_r[2];
  wire ctl_wr    = wr_en & sel_ctl;
  wire start_cmd = ctl_wr & pwdata_in[CTRL_START];
  wire cal_cmd   = ctl_wr & pwdata_in[CTRL_CAL];
  wire fclr_cmd  = ctl_wr & pwdata_in[CTRL_FCLR];
  wire [1:0] new_mode = pwdata_in[CTRL_MODE_LO +: 2];
  wire mode_chg  = ctl_wr & (mode_t'(new_mode) != ctrl_r.mode);
  wire in_contact = (ctrl_r.mode == MODE_CONTACT);
  wire in_batch   = (ctrl_r.mode == MODE_BATCH);

  //////////////////////////////////////////////////////////////////////////
  // Contact scaling: whole strokes and carried remainder.
  //////////////////////////////////////////////////////////////////////////
  // The sum is at most 9999 + 99, so the whole part stays below 128.
  wire [14:0] acc   = {1'b0, frac_r} + {1'b0, factor_r};
  wire [14:0] whole = acc / {1'b0, FRAC_ONE};
  wire [14:0] rem   = acc % {1'b0, FRAC_ONE};

  //////////////////////////////////////////////////////////////////////////
  // Batch size in strokes, from count or quantity form.
  //////////////////////////////////////////////////////////////////////////
  // Quantity form rounds up so the batch never under-doses.
  wire [16:0] qty_up   = {1'b0, qty_r} + {1'b0, vol_r} - 17'h0_0001;
  wire [16:0] qty_strk = qty_up / {1'b0, vol_r};
  wire [15:0] bsize    = ctrl_r.qty_form ? qty_strk[15:0]
                                         : batch_r;

  //////////////////////////////////////////////////////////////////////////
  // Backlog arithmetic.
  //////////////////////////////////////////////////////////////////////////
  wire        dec      = stroke_done_in & (pend_r != 16'h0000);
  wire [15:0] base     = pend_r - {15'h0000, dec};
  wire        c_trig   = in_contact & pulse & ~fault_r;
  wire        b_trig   = in_batch & (pulse | start_cmd) & ~fault_r;
  wire [16:0] c_sum    = {1'b0, base} + {2'b00, whole};
  wire [16:0] b_sum    = {1'b0, base} + {1'b0, bsize};
  wire [16:0] add_sum  = c_trig ? c_sum : b_sum;
  wire        trig_any = c_trig | b_trig;
  wire        overflow = trig_any & ctrl_r.mem_en
                         & (add_sum > BACKLOG_MAX);
  // Without memory a busy contact pump drops the new strokes.
  wire        discard  = c_trig & ~ctrl_r.mem_en
                         & (pend_r != 16'h0000);
  logic [15:0] pend_nxt;

  // Next backlog value, capped as the option demands.
  always_comb begin
    pend_nxt = base;
    if (mode_chg) begin
      pend_nxt = 16'h0000;
    end else if (overflow) begin
      pend_nxt = BACKLOG_MAX[15:0];
    end else if (c_trig) begin
      if (ctrl_r.mem_en) begin
        pend_nxt = c_sum[15:0];
      end else if (!discard) begin
        pend_nxt = {1'b0, whole};
      end
    end else if (b_trig) begin
      if (ctrl_r.mem_en) begin
        pend_nxt = b_sum[15:0];
      end else if (b_sum > {1'b0, bsize}) begin
        pend_nxt = bsize;
      end else begin
        pend_nxt = b_sum[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Calibration drift.
  //////////////////////////////////////////////////////////////////////////
  wire [6:0] diff  = (stroke_len_in > calpt_r) ? stroke_len_in - calpt_r
                                               : calpt_r - stroke_len_in;
  wire       drift = calv_r & (diff > DRIFT_TOL);

  //////////////////////////////////////////////////////////////////////////
  // Events.
  //////////////////////////////////////////////////////////////////////////
  wire [IRQ_W-1:0] ev;
  assign ev[IRQ_FAULT]   = overflow;
  assign ev[IRQ_DRIFT]   = drift;
  assign ev[IRQ_DISCARD] = discard;
  assign ev[IRQ_EMPTY]   = dec & (pend_r == 16'h0001);
  wire [IRQ_W-1:0] w1c = (wr_en & sel_irq) ? pwdata_in[IRQ_W-1:0]
                                           : {IRQ_W{1'b0}};

  //////////////////////////////////////////////////////////////////////////
  // Register valid writes.
  //////////////////////////////////////////////////////////////////////////
  wire [13:0] fac_w  = pwdata_in[13:0];
  wire        fac_ok = (fac_w >= FACTOR_MIN) & (fac_w <= FACTOR_MAX)
                       & (pwdata_in[31:14] == 18'h0_0000);
  wire        bat_ok = (pwdata_in[15:0] != 16'h0000)
                       & (pwdata_in[31:16] == 16'h0000);
  wire        vol_ok = (pwdata_in[15:0] != 16'h0000);

  // Control, factor and configuration registers.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_r   <= '{qty_form: 1'b0, mem_en: 1'b0, mode: MODE_MANUAL};
      factor_r <= FACTOR_RST;
      batch_r  <= BATCH_RST;
      qty_r    <= BATCH_RST;
      vol_r    <= VOL_RST;
      mask_r   <= {IRQ_W{1'b0}};
    end else begin
      if (ctl_wr) begin
        ctrl_r.mode     <= mode_t'(new_mode);
        ctrl_r.mem_en   <= pwdata_in[CTRL_MEM];
        ctrl_r.qty_form <= pwdata_in[CTRL_QTY];
      end
      if (mode_chg) begin
        factor_r <= FACTOR_RST;
      end else if (wr_en & sel_fac & fac_ok) begin
        factor_r <= fac_w;
      end
      if (wr_en & sel_bat & bat_ok) begin
        batch_r <= pwdata_in[15:0];
      end
      if (wr_en & sel_qty) begin
        qty_r <= pwdata_in[15:0];
      end
      if (wr_en & sel_vol & vol_ok) begin
        vol_r <= pwdata_in[15:0];
      end
      if (wr_en & sel_msk) begin
        mask_r <= pwdata_in[IRQ_W-1:0];
      end
    end
  end

  // Backlog, remainder and fault state.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pend_r  <= 16'h0000;
      frac_r  <= 14'h0000;
      fault_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      if (mode_chg) begin
        frac_r <= 14'h0000;
      end else if (c_trig & ~discard) begin
        frac_r <= rem[13:0];
      end
      // A new overflow wins over a clear in the same cycle.
      if (overflow) begin
        fault_r <= 1'b1;
      end else if (fclr_cmd | mode_chg) begin
        fault_r <= 1'b0;
      end
    end
  end

  // Calibration point, trigger synchroniser and sticky events.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      calv_r  <= 1'b0;
      calpt_r <= 7'h00;
      sync_r  <= 3'b000;
      irq_r   <= {IRQ_W{1'b0}};
    end else begin
      if (cal_cmd) begin
        calv_r  <= 1'b1;
        calpt_r <= stroke_len_in;
      end
      sync_r <= {sync_r[1:0], trig_in};
      irq_r  <= (irq_r & ~w1c) | ev;
    end
  end

  // Flash divider, free running.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= 1'b0;
    end else if (blink_cnt_r == 32'(BLINK_N - 1)) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read path.
  //////////////////////////////////////////////////////////////////////////
  wire [31:0] stat_w = {6'h00, calpt_r, drift, calv_r, fault_r, pend_r};
  wire [31:0] rd_mux =
      sel_ctl ? {28'h000_0000, ctrl_r} :
      sel_fac ? {18'h0_0000, factor_r} :
      sel_bat ? {16'h0000, batch_r} :
      sel_qty ? {16'h0000, qty_r} :
      sel_vol ? {16'h0000, vol_r} :
      sel_sta ? stat_w :
      sel_irq ? {28'h000_0000, irq_r} :
      sel_msk ? {28'h000_0000, mask_r} : 32'h0000_0000;

  // Read data is captured in the setup cycle, so it is ready in access.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= (psel_in & ~penable_in & ~pwrite_in) ? rd_mux
                                                         : 32'h0000_0000;
      pslverr_r <= psel_in & ~penable_in & ~mapped;
    end
  end

  assign prdata_out  = rd_en ? prdata_r : 32'h0000_0000;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & pslverr_r;

  //////////////////////////////////////////////////////////////////////////
  // Outputs.
  //////////////////////////////////////////////////////////////////////////
  assign stroke_req_out      = (pend_r != 16'h0000) & ~fault_r;
  assign ind_out.warn_lamp   = drift;
  assign ind_out.disp_flash  = drift & blink_r;
  assign ind_out.calib_flash = drift & blink_r;
  assign ind_out.mem_ind     = ctrl_r.mem_en;
  assign irq_out             = |(irq_r & mask_r);

  //////////////////////////////////////////////////////////////////////////
  // Assertions.
  //////////////////////////////////////////////////////////////////////////
  property p_int_factor;
    @(posedge clk_in) disable iff (reset_in)
    (c_trig & (frac_r == 14'h0000) & (factor_r % FRAC_ONE == 14'h0000))
      |-> (whole == 15'(factor_r / FRAC_ONE));
  endproperty
  a_int_factor: assert property (p_int_factor)
    else $error("integer factor gives wrong stroke count");
  property p_frac_carry;
    @(posedge clk_in) disable iff (reset_in)
    (c_trig & ~discard & ~mode_chg) |=> (frac_r ==
      14'((15'($past(frac_r)) + 15'($past(factor_r))) % 15'd100));
  endproperty
  a_frac_carry: assert property (p_frac_carry)
    else $error("fraction remainder not carried");
  property p_factor_range;
    @(posedge clk_in) disable iff (reset_in)
    (factor_r >= FACTOR_MIN) && (factor_r <= FACTOR_MAX);
  endproperty
  a_factor_range: assert property (p_factor_range)
    else $error("factor out of range");
  property p_mode_reset;
    @(posedge clk_in) disable iff (reset_in)
    mode_chg |=> (factor_r == FACTOR_RST) && (pend_r == 16'h0000);
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("mode change kept factor or backlog");
  property p_backlog_clear;
    @(posedge clk_in) disable iff (reset_in)
    mode_chg |=> !stroke_req_out;
  endproperty
  a_backlog_clear: assert property (p_backlog_clear)
    else $error("backlog survived mode change");
  property p_fault_cause;
    @(posedge clk_in) disable iff (reset_in)
    $rose(fault_r) |-> $past(overflow);
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("fault without overflow");
  property p_req_level;
    @(posedge clk_in) disable iff (reset_in)
    ((pend_r == 16'h0000) && !trig_any) |=> !stroke_req_out;
  endproperty
  a_req_level: assert property (p_req_level)
    else $error("stroke request without backlog");
  property p_drift_lamp;
    @(posedge clk_in) disable iff (reset_in)
    (calv_r && (diff > 7'h0A)) |-> ind_out.warn_lamp;
  endproperty
  a_drift_lamp: assert property (p_drift_lamp)
    else $error("drift lamp dark beyond tolerance");
  property p_edge_once;
    @(posedge clk_in) disable iff (reset_in)
    $rose(trig_in) |-> ##2 pulse ##1 !pulse;
  endproperty
  a_edge_once: assert property (p_edge_once)
    else $error("trigger edge not counted once");
  property p_batch_cap;
    @(posedge clk_in) disable iff (reset_in)
    (in_batch && !ctrl_r.mem_en && b_trig) |=> (pend_r <= $past(bsize));
  endproperty
  a_batch_cap: assert property (p_batch_cap)
    else $error("batch backlog above batch size");
  property p_discard_hold;
    @(posedge clk_in) disable iff (reset_in)
    (discard && !dec && !mode_chg) |=> $stable(pend_r);
  endproperty
  a_discard_hold: assert property (p_discard_hold)
    else $error("busy contact pulse changed backlog");
  property p_dec_one;
    @(posedge clk_in) disable iff (reset_in)
    (dec && !trig_any && !mode_chg) |=> pend_r == $past(pend_r) - 16'h0001;
  endproperty
  a_dec_one: assert property (p_dec_one)
    else $error("executed stroke not counted off");
  c_contact: cover property (@(posedge clk_in) c_trig ##[1:20] c_trig);
  c_batch:   cover property (@(posedge clk_in) b_trig ##[1:50] ev[IRQ_EMPTY]);
  c_fault:   cover property (@(posedge clk_in) overflow);
  c_drift:   cover property (@(posedge clk_in) $rose(drift));

endmodule // pulse_to_stroke_scaler
`default_nettype wire

/* File: verilog/stroke_scaler_pkg.sv */
// Package: register map, field positions, reset values and types.
`default_nettype none
package stroke_scaler_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_FACTOR = 8'h04;
  localparam logic [7:0] OFF_BATCH  = 8'h08;
  localparam logic [7:0] OFF_QTY    = 8'h0C;
  localparam logic [7:0] OFF_VOL    = 8'h10;
  localparam logic [7:0] OFF_STAT   = 8'h14;
  localparam logic [7:0] OFF_IRQ    = 8'h18;
  localparam logic [7:0] OFF_MASK   = 8'h1C;
  // Control register field positions.
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_MEM     = 2;
  localparam int CTRL_QTY     = 3;
  localparam int CTRL_START   = 4;
  localparam int CTRL_CAL     = 5;
  localparam int CTRL_FCLR    = 6;
  // Status register field positions.
  localparam int STAT_FAULT   = 16;
  localparam int STAT_CALV    = 17;
  localparam int STAT_DRIFT   = 18;
  localparam int STAT_CALPT   = 19;
  // Interrupt bit positions.
  localparam int IRQ_FAULT    = 0;
  localparam int IRQ_DRIFT    = 1;
  localparam int IRQ_DISCARD  = 2;
  localparam int IRQ_EMPTY    = 3;
  localparam int IRQ_W        = 4;
  // Factor in hundredths: 0.01 .. 99.99, reset value 1.00.
  localparam logic [13:0] FACTOR_MIN = 14'h0001;
  localparam logic [13:0] FACTOR_MAX = 14'h270F;
  localparam logic [13:0] FACTOR_RST = 14'h0064;
  localparam logic [13:0] FRAC_ONE   = 14'h0064;
  // Batch size and backlog limits.
  localparam logic [15:0] BATCH_RST  = 16'h0001;
  localparam logic [15:0] VOL_RST    = 16'h0001;
  localparam logic [16:0] BACKLOG_MAX = 17'h0_FFFF;
  // Calibration holds within this many stroke-length divisions.
  localparam logic [6:0] DRIFT_TOL  = 7'h0A;
  // Display flash half period.
  localparam int CLK_HZ       = 20_000_000;
  localparam int BLINK_MS     = 500;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
  // Operating modes.
  typedef enum logic [1:0] {
    MODE_MANUAL, MODE_CONTACT, MODE_BATCH, MODE_OTHER
  } mode_t;
  // Control register contents.
  typedef struct packed {
    logic  qty_form;
    logic  mem_en;
    mode_t mode;
  } ctrl_t;
  // Indicator outputs grouped together.
  typedef struct packed {
    logic warn_lamp;
    logic disp_flash;
    logic calib_flash;
    logic mem_ind;
  } ind_t;
endpackage
`default_nettype wire
